// [verilog/bpp_pkg.sv]
// Contract
// - Target fetch one cycle after branch fetch
// - History table 4096 entries, two bits
// - Index from PC[13:3] and history vector
// - Counters saturate up taken, down not
// - Predict taken on top two values
// - Cache fills leave history untouched
// - Pending predictions: four, one, one per stage; code caps stages 3 and 4 together at two, i_adv_s4 unused
// - Resolved outcome updates history entry
// - Branch mispredict traps, restarts correct PC
// - Twelve entry return stack, opcode decoded
// - Stack holds cache index, wraps silently
// - Push, pop, pop-push per instruction kind
// - Indirect jumps use displacement index hint
// - Return way from history upper bit
// - Upper PC bits from predicted way tag
// - PC mismatch traps, restarts, updates history
// - No stack prediction in privileged mode
package bpp_pkg;
	localparam int BPP_HIST_ENTRIES = 4096;
	localparam int BPP_HIST_IDX_W   = 12;
	localparam int BPP_GHIST_W      = 5;
	localparam int BPP_PC_LO        = 3;
	localparam int BPP_PC_HI        = 13;
	localparam int BPP_RAS_DEPTH    = 12;
	localparam int BPP_CIDX_W       = 10;
	localparam int BPP_PC_W         = 43;
	localparam int BPP_TAG_W        = BPP_PC_W - BPP_CIDX_W - 2;
	localparam int BPP_S2_MAX       = 4;
	localparam int BPP_S3_MAX       = 1;
	localparam int BPP_S4_MAX       = 1;
	localparam int BPP_TGT_LAT      = 1;
	localparam logic [1:0] BPP_CNT_RESET = 2'h1;
	localparam logic [1:0] BPP_CNT_MAX   = 2'h3;
	localparam logic [1:0] BPP_CNT_MIN   = 2'h0;

	typedef enum logic [2:0] {
		BPP_OP_NONE      = 3'b000,
		BPP_OP_COND      = 3'b001,
		BPP_OP_CALL      = 3'b010,
		BPP_OP_RETURN    = 3'b011,
		BPP_OP_COROUTINE = 3'b100,
		BPP_OP_INDIRECT  = 3'b101,
		BPP_OP_PRIV_RET  = 3'b110,
		BPP_OP_PRIV_CALL = 3'b111
	} bpp_op_t;
endpackage

// [verilog/bpp_return_stack.sv]
`timescale 1ns/10ps
module bpp_return_stack
	import bpp_pkg::*;
#(
	parameter int DEPTH = BPP_RAS_DEPTH,
	parameter int W     = BPP_CIDX_W
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset_n,
	input  wire logic         i_push,
	input  wire logic         i_pop,
	input  wire logic [W-1:0] i_push_idx,
	output logic      [W-1:0] o_top_idx
);
	localparam int PW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2) $error("return stack depth too small");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] ptr_q;
	logic [PW-1:0] ptr_dn;
	logic [PW-1:0] ptr_up;
	logic [PW-1:0] wr_ptr;

	// Circular pointer, no overflow detection
	assign ptr_dn = (ptr_q == '0) ? PW'(DEPTH - 1) : ptr_q - 1'b1;
	assign ptr_up = (ptr_q == PW'(DEPTH - 1)) ? '0 : ptr_q + 1'b1;
	assign wr_ptr = i_pop ? ptr_q : ptr_up;
	assign o_top_idx = mem_q[ptr_q];

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ptr_q <= '0;
		end else if (i_pop && !i_push) begin
			ptr_q <= ptr_dn;
		end else if (i_push && !i_pop) begin
			ptr_q <= ptr_up;
		end
	end

	// Pop then push rewrites the top slot in place
	generate
		for (genvar g = 0; g < DEPTH; g++) begin : g_ent
			always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					mem_q[g] <= '0;
				end else if (i_push && wr_ptr == PW'(g)) begin
					mem_q[g] <= i_push_idx;
				end
			end
		end
	endgenerate

	ovf_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_push && !i_pop && ptr_q == PW'(DEPTH - 1)) |=> ptr_q == '0)
		else $error("stack pointer did not wrap on overflow");
endmodule // bpp_return_stack

// [verilog/bpp_branch_predictor.sv]
`timescale 1ns/10ps
module bpp_branch_predictor
	import bpp_pkg::*;
#(
	parameter int ENTRIES = BPP_HIST_ENTRIES,
	parameter int GHIST_W = BPP_GHIST_W,
	parameter int RAS_N   = BPP_RAS_DEPTH
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_reset_n,
	// Fetch side
	input  wire logic                  i_fetch_valid,
	input  wire bpp_op_t               i_fetch_op,
	input  wire logic [BPP_PC_W-1:0]   i_fetch_pc,
	input  wire logic [15:0]           i_displacement_field,
	input  wire logic [BPP_PC_W-1:0]   i_direct_target,
	input  wire logic                  i_privileged_library_mode,
	input  wire logic                  i_cache_fill,
	// Tags of both cache ways at the looked-up index
	output logic      [BPP_CIDX_W-1:0] o_tag_lookup_idx,
	input  wire logic [BPP_TAG_W-1:0]  i_way0_tag,
	input  wire logic [BPP_TAG_W-1:0]  i_way1_tag,
	// Prediction to the instruction cache
	output logic                       o_pred_valid,
	output logic [BPP_PC_W-1:0]        o_pred_pc,
	output logic                       o_pred_way,
	output logic                       o_pred_taken,
	output logic                       o_pred_from_stack,
	output logic                       o_pred_stall,
	// Resolution from execution units
	input  wire logic                  i_resolve_valid,
	input  wire logic                  i_resolve_is_cond,
	input  wire logic                  i_resolve_taken,
	input  wire logic [BPP_PC_W-1:0]   i_resolve_actual_pc,
	// Stage advance from the pipeline
	input  wire logic                  i_adv_s3,
	input  wire logic                  i_adv_s4,
	// Trap and restart to the fetch unit
	output logic                       o_mispredict_trap,
	output logic [BPP_PC_W-1:0]        o_restart_pc,
	output logic                       o_flush_younger
);
	localparam int IW  = $clog2(ENTRIES);
	localparam int PCN = BPP_PC_HI - BPP_PC_LO + 1;
	localparam int QN  = BPP_S2_MAX + BPP_S3_MAX + BPP_S4_MAX;
	localparam int QW  = $clog2(QN + 1);
	initial begin
		if (IW != PCN + 1 || IW != BPP_HIST_IDX_W) $error("history size unsupported");
		if (GHIST_W < 2 || GHIST_W > PCN) $error("history vector width unsupported");
		if (RAS_N != BPP_RAS_DEPTH) $error("stack depth unsupported");
	end

	// ========================================
	// History table
	// ========================================
	logic [1:0]         hist_q [ENTRIES];
	logic [GHIST_W-1:0] ghist_q;
	logic [IW-1:0]      fetch_idx;
	logic [1:0]         fetch_cnt;
	logic               is_cond;
	logic               is_stack_op;

	// PC bits XOR history vector, top bit held at zero for all lookups
	assign fetch_idx = {1'b0, i_fetch_pc[BPP_PC_HI:BPP_PC_LO]}
		^ {{(IW - GHIST_W){1'b0}}, ghist_q};
	assign fetch_cnt = hist_q[fetch_idx];
	assign is_cond   = (i_fetch_op == BPP_OP_COND);
	assign is_stack_op = (i_fetch_op == BPP_OP_RETURN) || (i_fetch_op == BPP_OP_COROUTINE)
		|| (i_fetch_op == BPP_OP_PRIV_RET);

	// ========================================
	// Pending predictions queue
	// ========================================
	logic [IW-1:0]       pq_idx_q  [QN];
	logic                pq_pred_q [QN];
	logic [BPP_PC_W-1:0] pq_pc_q   [QN];
	logic                pq_cond_q [QN];
	logic [QW-1:0]       pq_cnt_q;
	logic [QW-1:0]       s2_cnt_q;
	logic [1:0]          s34_cnt_q;
	logic                take_new;
	logic                do_res;
	logic                mismatch;
	logic                full;

	assign full     = (s2_cnt_q == QW'(BPP_S2_MAX));
	assign o_pred_stall = full;
	assign take_new = i_fetch_valid && !full && !o_mispredict_trap;
	assign do_res   = i_resolve_valid && (pq_cnt_q != '0);
	assign mismatch = pq_cond_q[0] ? (pq_pred_q[0] != i_resolve_taken)
		: (pq_pc_q[0] != i_resolve_actual_pc);

	// ========================================
	// Return stack
	// ========================================
	logic [BPP_CIDX_W-1:0] ras_top;
	logic                  ras_push;
	logic                  ras_pop;
	logic [BPP_PC_W-1:0]   pc_plus4;

	assign pc_plus4 = i_fetch_pc + BPP_PC_W'(4);
	assign ras_push = take_new && (i_fetch_op == BPP_OP_CALL || i_fetch_op == BPP_OP_COROUTINE
		|| i_fetch_op == BPP_OP_PRIV_CALL);
	assign ras_pop  = take_new && is_stack_op;

	bpp_return_stack #(
		.DEPTH (RAS_N),
		.W     (BPP_CIDX_W)
	) u_ras (
		.i_sys_clk  (i_sys_clk),
		.i_reset_n  (i_reset_n),
		.i_push     (ras_push),
		.i_pop      (ras_pop),
		.i_push_idx (pc_plus4[BPP_CIDX_W+1:2]),
		.o_top_idx  (ras_top)
	);

	// ========================================
	// Target computation
	// ========================================
	logic                  way_pred;
	logic [BPP_CIDX_W-1:0] hint_idx;
	logic [BPP_PC_W-1:0]   tgt_d;
	logic                  taken_d;

	assign way_pred = fetch_cnt[1];
	assign hint_idx = i_displacement_field[BPP_CIDX_W-1:0];
	assign o_tag_lookup_idx = (i_fetch_op == BPP_OP_INDIRECT) ? hint_idx : ras_top;

	always_comb begin
		tgt_d   = pc_plus4;
		taken_d = 1'b0;
		case (i_fetch_op)
			BPP_OP_COND: begin
				taken_d = fetch_cnt[1];
				tgt_d   = fetch_cnt[1] ? i_direct_target : pc_plus4;
			end
			BPP_OP_CALL, BPP_OP_PRIV_CALL: begin
				taken_d = 1'b1;
				tgt_d   = i_direct_target;
			end
			BPP_OP_INDIRECT: begin
				taken_d = 1'b1;
				tgt_d   = {(way_pred ? i_way1_tag : i_way0_tag), hint_idx, 2'h0};
			end
			BPP_OP_RETURN, BPP_OP_COROUTINE, BPP_OP_PRIV_RET: begin
				taken_d = 1'b1;
				if (!i_privileged_library_mode) begin
					tgt_d = {(way_pred ? i_way1_tag : i_way0_tag), ras_top, 2'h0};
				end
			end
			default: begin
				tgt_d   = pc_plus4;
				taken_d = 1'b0;
			end
		endcase
	end

	// One cycle to compute the target, cache access follows
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pred_valid      <= 1'b0;
			o_pred_pc         <= '0;
			o_pred_way        <= 1'b0;
			o_pred_taken      <= 1'b0;
			o_pred_from_stack <= 1'b0;
		end else begin
			o_pred_valid      <= take_new && (i_fetch_op != BPP_OP_NONE);
			o_pred_pc         <= tgt_d;
			o_pred_way        <= way_pred;
			o_pred_taken      <= taken_d;
			o_pred_from_stack <= is_stack_op && !i_privileged_library_mode;
		end
	end

	// ========================================
	// History vector and table update
	// ========================================
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ghist_q <= '0;
		end else if (do_res && pq_cond_q[0]) begin
			ghist_q <= {ghist_q[GHIST_W-2:0], i_resolve_taken};
		end
	end

	// Cache fill has no path into the table
	generate
		for (genvar g = 0; g < ENTRIES; g++) begin : g_hist
			always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					hist_q[g] <= BPP_CNT_RESET;
				end else if (do_res && pq_idx_q[0] == IW'(g)) begin
					if (pq_cond_q[0]) begin
						if (i_resolve_taken && hist_q[g] != BPP_CNT_MAX) begin
							hist_q[g] <= hist_q[g] + 2'h1;
						end else if (!i_resolve_taken && hist_q[g] != BPP_CNT_MIN) begin
							hist_q[g] <= hist_q[g] - 2'h1;
						end
					end else if (mismatch) begin
						hist_q[g] <= {~hist_q[g][1], hist_q[g][0]};
					end
				end
			end
		end
	endgenerate

	// ========================================
	// Queue bookkeeping
	// ========================================
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pq_cnt_q <= '0;
		end else if (do_res && mismatch) begin
			pq_cnt_q <= '0;
		end else begin
			pq_cnt_q <= pq_cnt_q - QW'(do_res) + QW'(take_new && i_fetch_op != BPP_OP_NONE);
		end
	end

	logic adv_ok;
	logic res_s2;
	logic res_s34;

	// Oldest resolves out of stage 3/4 first, otherwise out of stage 2
	assign res_s34 = do_res && (s34_cnt_q != '0);
	assign res_s2  = do_res && (s34_cnt_q == '0) && (s2_cnt_q != '0);
	assign adv_ok  = i_adv_s3 && (s2_cnt_q > QW'(res_s2)) && (s34_cnt_q < 2'h2);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s2_cnt_q  <= '0;
			s34_cnt_q <= '0;
		end else if (do_res && mismatch) begin
			s2_cnt_q  <= '0;
			s34_cnt_q <= '0;
		end else begin
			s2_cnt_q  <= s2_cnt_q + QW'(take_new && i_fetch_op != BPP_OP_NONE)
				- QW'(adv_ok) - QW'(res_s2);
			s34_cnt_q <= s34_cnt_q + 2'(adv_ok) - 2'(res_s34);
		end
	end

	generate
		for (genvar g = 0; g < QN; g++) begin : g_pq
			always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					pq_idx_q[g]  <= '0;
					pq_pred_q[g] <= 1'b0;
					pq_pc_q[g]   <= '0;
					pq_cond_q[g] <= 1'b0;
				end else if (take_new && i_fetch_op != BPP_OP_NONE
					&& QW'(g) == pq_cnt_q - QW'(do_res)) begin
					pq_idx_q[g]  <= fetch_idx;
					pq_pred_q[g] <= taken_d;
					pq_pc_q[g]   <= tgt_d;
					pq_cond_q[g] <= is_cond;
				end else if (do_res && g < QN - 1) begin
					pq_idx_q[g]  <= pq_idx_q[g+1];
					pq_pred_q[g] <= pq_pred_q[g+1];
					pq_pc_q[g]   <= pq_pc_q[g+1];
					pq_cond_q[g] <= pq_cond_q[g+1];
				end
			end
		end
	endgenerate

	// ========================================
	// Trap and restart
	// ========================================
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mispredict_trap <= 1'b0;
			o_flush_younger   <= 1'b0;
			o_restart_pc      <= '0;
		end else begin
			o_mispredict_trap <= do_res && mismatch;
			o_flush_younger   <= do_res && mismatch;
			if (do_res && mismatch) begin
				o_restart_pc <= i_resolve_actual_pc;
			end
		end
	end

	// ========================================
	// Checks
	// ========================================
	tgt_latency_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(take_new && i_fetch_op == BPP_OP_COND) |=> o_pred_valid && o_pred_pc == $past(tgt_d))
		else $error("target not presented one cycle after fetch");
	cnt_sat_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(do_res && pq_cond_q[0] && i_resolve_taken && hist_q[pq_idx_q[0]] == BPP_CNT_MAX)
		|=> hist_q[$past(pq_idx_q[0])] == BPP_CNT_MAX)
		else $error("counter wrapped past maximum");
	pred_dir_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(take_new && is_cond) |=> o_pred_taken == $past(fetch_cnt[1]))
		else $error("direction not from counter upper half");
	fill_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_cache_fill && !do_res) |=> hist_q[$past(fetch_idx)] == $past(fetch_cnt))
		else $error("history changed on cache fill");
	s2_limit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s2_cnt_q <= QW'(BPP_S2_MAX) && s34_cnt_q <= 2'h2)
		else $error("too many pending predictions");
	trap_flush_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(do_res && mismatch) |=> o_mispredict_trap && o_restart_pc == $past(i_resolve_actual_pc)
		##1 pq_cnt_q <= QW'(1))
		else $error("mispredict did not trap and flush");
	priv_nostack_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(take_new && is_stack_op && i_privileged_library_mode)
		|=> !o_pred_from_stack && o_pred_pc == $past(pc_plus4))
		else $error("stack used in privileged mode");
	way_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(take_new && is_stack_op) |=> o_pred_way == $past(fetch_cnt[1]))
		else $error("way not from history upper bit");
endmodule // bpp_branch_predictor

// [testbench/bpp_tag_store_model.sv]
`timescale 1ns/10ps
module bpp_tag_store_model
	import bpp_pkg::*;
(
	input  wire logic [BPP_CIDX_W-1:0] i_idx,
	output logic      [BPP_TAG_W-1:0]  o_way0_tag,
	output logic      [BPP_TAG_W-1:0]  o_way1_tag
);
	// Tags differ per way and per index
	assign o_way0_tag = {11'h2A6, i_idx, ~i_idx};
	assign o_way1_tag = {11'h5C3, i_idx, ~i_idx};
endmodule // bpp_tag_store_model

// [testbench/tb_branch_pc_predictor.sv]
`timescale 1ns/10ps
module tb_branch_pc_predictor;
	import bpp_pkg::*;
	// ==========================================================
	// Signals
	logic                  sys_clk, reset_n, fv, priv, fill, rv, rcond, rtaken, adv;
	bpp_op_t               op;
	logic [BPP_PC_W-1:0]   fpc, dtgt, rpc, ppc, rspc, c_pc, c_rst, p;
	logic [15:0]           displacement_field;
	logic [BPP_CIDX_W-1:0] lidx, c_idx;
	logic [BPP_TAG_W-1:0]  t0, t1;
	logic                  pv, pway, ptaken, pstack, stall, trap, flush;
	logic                  c_pv, c_taken, c_way, c_stack, c_trap, c_flush;
	logic [BPP_CIDX_W-1:0] stk [BPP_RAS_DEPTH];
	int                    sp, errors, n_tests;

	bpp_branch_predictor dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_fetch_valid(fv),
		.i_fetch_op(op), .i_fetch_pc(fpc), .i_displacement_field(displacement_field), .i_direct_target(dtgt),
		.i_privileged_library_mode(priv), .i_cache_fill(fill), .o_tag_lookup_idx(lidx),
		.i_way0_tag(t0), .i_way1_tag(t1), .o_pred_valid(pv), .o_pred_pc(ppc), .o_pred_way(pway),
		.o_pred_taken(ptaken), .o_pred_from_stack(pstack), .o_pred_stall(stall),
		.i_resolve_valid(rv), .i_resolve_is_cond(rcond), .i_resolve_taken(rtaken),
		.i_resolve_actual_pc(rpc), .i_adv_s3(adv), .i_adv_s4(1'b0),
		.o_mispredict_trap(trap), .o_restart_pc(rspc), .o_flush_younger(flush));
	bpp_tag_store_model tags (.i_idx(lidx), .o_way0_tag(t0), .o_way1_tag(t1));

	// ==========================================================
	// Expectation helpers
	function automatic logic [BPP_PC_W-1:0] stk_pc(input logic w, input logic [9:0] i);
		return {w ? 11'h5C3 : 11'h2A6, i, ~i, i, 2'h0};
	endfunction
	function automatic logic [BPP_CIDX_W-1:0] idx_of(input logic [BPP_PC_W-1:0] pc);
		logic [BPP_PC_W-1:0] n;
		n = pc + 43'h4;
		return n[11:2];
	endfunction
	// Region bits keep history-table indices of scenarios apart
	function automatic logic [BPP_PC_W-1:0] region_pc(input logic [5:0] k);
		logic [BPP_PC_W-1:0] r;
		r = {11'($urandom()), $urandom()};
		r[13:8] = k;
		r[1:0] = 2'h0;
		return r;
	endfunction

	// ==========================================================
	// Drivers and checks
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic fetch(input bpp_op_t o, input logic [BPP_PC_W-1:0] pc);
		fv   = 1'b1;
		op   = o;
		fpc  = pc;
		dtgt = pc + 43'h40;
		displacement_field = 16'($urandom());
		#2 c_idx = lidx;
		@(posedge sys_clk);
		#1;
		c_pv    = pv;
		c_taken = ptaken;
		c_way   = pway;
		c_stack = pstack;
		c_pc    = ppc;
	endtask
	task automatic resolve(input logic cd, input logic tk, input logic [BPP_PC_W-1:0] apc);
		fv     = 1'b0;
		rv     = 1'b1;
		rcond  = cd;
		rtaken = tk;
		rpc    = apc;
		@(posedge sys_clk);
		#1;
		rv      = 1'b0;
		c_trap  = trap;
		c_flush = flush;
		c_rst   = rspc;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic adv_one;
		fv  = 1'b0;
		adv = 1'b1;
		@(posedge sys_clk);
		#1;
		adv = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic cond_step(input logic [BPP_PC_W-1:0] pc, input logic et, tk, ex);
		fetch(BPP_OP_COND, pc);
		chk("pred_valid", 1, c_pv);
		chk("pred_taken", et, c_taken);
		resolve(1'b1, tk, pc + 43'h100);
		chk("trap", ex, c_trap);
		if (ex) chk("restart_pc", pc + 43'h100, c_rst);
	endtask
	task automatic push_step(input bpp_op_t o, input logic [BPP_PC_W-1:0] pc);
		stk[sp] = idx_of(pc);
		sp = (sp + 1) % BPP_RAS_DEPTH;
		fetch(o, pc);
		resolve(1'b0, 1'b1, pc + 43'h40);
	endtask
	task automatic pop_step(input bpp_op_t o, input logic [BPP_PC_W-1:0] pc, input logic w, bad);
		logic [9:0]          e;
		logic [BPP_PC_W-1:0] a;
		sp = (sp + BPP_RAS_DEPTH - 1) % BPP_RAS_DEPTH;
		e = stk[sp];
		a = bad ? stk_pc(w, e) + 43'h1000 : stk_pc(w, e);
		fetch(o, pc);
		chk("lookup_idx", e, c_idx);
		chk("pred_pc", stk_pc(w, e), c_pc);
		chk("pred_way", w, c_way);
		chk("from_stack", 1, c_stack);
		resolve(1'b0, 1'b1, a);
		chk("trap", bad, c_trap);
		if (bad) chk("restart_pc", a, c_rst);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		errors++;
		$display("BAD watchdog expected finish seen timeout");
		give_verdict();
	end
	initial begin
		reset_n = 1'b0;
		fv      = 1'b0;
		op      = BPP_OP_NONE;
		fpc     = '0;
		dtgt    = '0;
		displacement_field    = '0;
		priv    = 1'b0;
		fill    = 1'b0;
		rv      = 1'b0;
		rcond   = 1'b0;
		rtaken  = 1'b0;
		rpc     = '0;
		adv     = 1'b0;
		errors  = 0;
		n_tests = 0;
		sp      = 0;
		void'($urandom(18));
		repeat (16) @(posedge sys_clk);
		#1 chk("pred_valid", 0, pv);
		chk("trap", 0, trap);
		chk("restart_pc", 0, rspc);
		reset_n = 1'b1;
		@(posedge sys_clk);
		#1;
		// Saturating up, history held at all ones
		p = region_pc(6'h1);
		repeat (5) begin
			fetch(BPP_OP_COND, p);
			resolve(1'b1, 1'b1, p + 43'h100);
		end
		p = region_pc(6'h2);
		cond_step(p, 1'b0, 1'b1, 1'b1);
		fill = 1'b1;
		cond_step(p, 1'b1, 1'b1, 1'b0);
		fill = 1'b0;
		cond_step(p, 1'b1, 1'b1, 1'b0);
		cond_step(p, 1'b1, 1'b0, 1'b1);
		$display("test counter_up done");
		// Saturating down, history held at all zeros
		p = region_pc(6'h3);
		repeat (5) begin
			fetch(BPP_OP_COND, p);
			resolve(1'b1, 1'b0, p + 43'h100);
		end
		p = region_pc(6'h4);
		cond_step(p, 1'b0, 1'b0, 1'b0);
		cond_step(p, 1'b0, 1'b0, 1'b0);
		cond_step(p, 1'b0, 1'b1, 1'b1);
		$display("test counter_down done");
		// Pending limits and flush
		p = region_pc(6'h5);
		for (int i = 0; i < 4; i++) fetch(BPP_OP_COND, p + 43'(i * 8));
		chk("stall", 1, stall);
		fetch(BPP_OP_COND, p + 43'h20);
		chk("refused", 0, c_pv);
		for (int i = 0; i < 2; i++) begin
			adv_one();
			chk("stall", 0, stall);
			fetch(BPP_OP_COND, p + 43'h28);
			chk("pred_valid", 1, c_pv);
		end
		adv_one();
		chk("stall", 1, stall);
		resolve(1'b1, 1'b1, p + 43'h100);
		chk("trap", 1, c_trap);
		chk("flush", 1, c_flush);
		chk("stall", 0, stall);
		fetch(BPP_OP_NONE, region_pc(6'hB));
		chk("none_valid", 0, c_pv);
		$display("test pending done");
		// Return stack with wrap both ways
		for (int i = 0; i < 13; i++) begin
			push_step(i[0] ? BPP_OP_PRIV_CALL : BPP_OP_CALL, region_pc(6'h6));
		end
		for (int i = 0; i < 13; i++) begin
			pop_step(i[0] ? BPP_OP_PRIV_RET : BPP_OP_RETURN, region_pc(6'h7),
				1'b0, 1'b0);
		end
		push_step(BPP_OP_CALL, region_pc(6'h6));
		p = region_pc(6'h7);
		pop_step(BPP_OP_COROUTINE, p, 1'b0, 1'b0);
		stk[sp] = idx_of(p);
		sp = (sp + 1) % BPP_RAS_DEPTH;
		pop_step(BPP_OP_RETURN, region_pc(6'h7), 1'b0, 1'b0);
		$display("test stack done");
		// Way from history, PC mismatch trap
		push_step(BPP_OP_CALL, region_pc(6'h6));
		p = region_pc(6'h8);
		pop_step(BPP_OP_RETURN, p, 1'b0, 1'b1);
		push_step(BPP_OP_CALL, region_pc(6'h6));
		pop_step(BPP_OP_RETURN, p, 1'b1, 1'b0);
		// Index hint leaves the stack alone
		push_step(BPP_OP_CALL, region_pc(6'h6));
		fetch(BPP_OP_INDIRECT, region_pc(6'h9));
		chk("hint_idx", displacement_field[9:0], c_idx);
		chk("hint_pc", stk_pc(1'b0, displacement_field[9:0]), c_pc);
		resolve(1'b0, 1'b1, stk_pc(1'b0, displacement_field[9:0]));
		pop_step(BPP_OP_RETURN, region_pc(6'h7), 1'b0, 1'b0);
		// No stack prediction in privileged mode
		push_step(BPP_OP_CALL, region_pc(6'h6));
		priv = 1'b1;
		p = region_pc(6'hA);
		fetch(BPP_OP_RETURN, p);
		// Stack still pops in privileged mode
		sp = (sp + BPP_RAS_DEPTH - 1) % BPP_RAS_DEPTH;
		chk("from_stack", 0, c_stack);
		chk("priv_pc", p + 43'h4, c_pc);
		resolve(1'b0, 1'b1, p + 43'h2000);
		chk("trap", 1, c_trap);
		priv = 1'b0;
		$display("test jumps done");
		give_verdict();
	end
endmodule // tb_branch_pc_predictor
